/* core/sbr_regs.svh */
/*
 * Register offsets, reset values and field positions of the burst framer.
 * Assumes byte addresses on an 8-bit register port with 32-bit words.
 */
`ifndef SBR_REGS_SVH
`define SBR_REGS_SVH

// =====================================================================
// Register offsets.
`define SBR_BMAX_OFS      8'h00
`define SBR_BSHORT_OFS    8'h04
`define SBR_BMIN_OFS      8'h08
`define SBR_STATUS_OFS    8'h0c

// =====================================================================
// Reset values of the burst settings, in bytes.
`define SBR_BMAX_RST      16'h0100
`define SBR_BSHORT_RST    16'h0040

// =====================================================================
// Field positions.
`define SBR_WORD_SHIFT    3
`define SBR_ST_OPEN_BIT   16
`define SBR_ST_RDY_BIT    17
`define SBR_ST_RXCNT_LSB  24
`define SBR_MTY_HALF_BIT  3

`endif

/* core/sbr_pkg.sv */
/*
 * Types shared by the burst framer and its receive deframer.
 * Assumes a single 128-bit segment and 64-bit link words.
 */
package sbr_pkg;

    // =================================================================
    // One segment of the local bus, transmit and receive alike.
    typedef struct packed {
        logic         ena;
        logic         sop;
        logic         eop;
        logic         err;
        logic         bctl;
        logic [10:0]  chan;
        logic [3:0]   mty;
        logic [127:0] data;
    } sbr_seg_type;

    // =================================================================
    // One word on the link side, data or control.
    typedef struct packed {
        logic        valid;
        logic        ctl;
        logic [63:0] data;
    } sbr_link_type;

    typedef enum logic [1:0] {
        CW_IDLE,
        CW_BURST,
        CW_RSVD2,
        CW_RSVD3
    } sbr_cw_kind_type;

    // Control word layout; eop fields describe the burst just closed.
    typedef struct packed {
        sbr_cw_kind_type kind;
        logic            sop;
        logic            eop;
        logic            err;
        logic            crc_bad;
        logic [2:0]      mty;
        logic [10:0]     chan;
        logic [43:0]     rsvd;
    } sbr_cw_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CTL,
        ST_DHI,
        ST_DLO,
        ST_PAD
    } sbr_tx_state_type;

endpackage

/* core/sbr_rx_deframe.sv */
/*
 * Receive deframer: turns link words into local bus segments.
 * Assumes link words arrive on mclk_i from the lane logic, no back-pressure.
 */
`timescale 1ns/10ps
`include "sbr_regs.svh"

module sbr_rx_deframe
    import sbr_pkg::*;
(
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire sbr_link_type link_i,
    output sbr_seg_type       seg_o
);

    // =================================================================
    // Assembly state.
    logic [63:0]  acc_hi;
    logic         have_hi;
    sbr_seg_type  pend;
    logic         pend_valid;
    logic [10:0]  cur_chan;
    logic         sop_next;

    sbr_cw_type cw;
    assign cw = sbr_cw_type'(link_i.data);

    // Decoded link events.
    wire is_data  = link_i.valid & ~link_i.ctl;
    wire is_ctl   = link_i.valid & link_i.ctl;
    wire is_eop   = is_ctl & cw.eop;
    wire is_burst = is_ctl & (cw.kind == CW_BURST);
    wire pkt_err  = cw.err | cw.crc_bad;

    // A held segment only learns it is the last one when the next word
    // arrives, so segments are emitted one link word late.
    wire emit_pend = is_data & ~have_hi & pend_valid;
    wire emit_eop  = is_eop & (have_hi | pend_valid);

    wire [3:0] eop_mty = {have_hi, cw.mty};

    // =================================================================
    // Output segment; all fields are zero unless the enable is set.
    sbr_seg_type next_seg;
    always_comb begin
        next_seg = '0;
        if (emit_pend) begin
            next_seg = pend;
            next_seg.ena = 1'b1;
        end else if (emit_eop) begin
            next_seg = pend;
            if (have_hi) begin
                next_seg.data = {acc_hi, 64'h0};
                next_seg.chan = cur_chan;
                next_seg.sop  = sop_next;
            end
            next_seg.ena = 1'b1;
            next_seg.eop = 1'b1;
            next_seg.err = pkt_err;
            next_seg.mty = eop_mty;
            if (pkt_err) begin
                next_seg.mty[2:0] = 3'h0;
            end
        end
    end

    // Registered outputs.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            seg_o <= '0;
        end else begin
            seg_o <= next_seg;
        end
    end

    // =================================================================
    // Word assembly and burst tracking.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            acc_hi     <= 64'h0;
            have_hi    <= 1'b0;
            pend       <= '0;
            pend_valid <= 1'b0;
            cur_chan   <= 11'h0;
            sop_next   <= 1'b0;
        end else if (is_data) begin
            if (!have_hi) begin
                acc_hi  <= link_i.data;
                have_hi <= 1'b1;
                if (emit_pend) begin
                    pend_valid <= 1'b0;
                end
            end else begin
                pend       <= '0;
                pend.data  <= {acc_hi, link_i.data};
                pend.chan  <= cur_chan;
                pend.sop   <= sop_next;
                pend_valid <= 1'b1;
                have_hi    <= 1'b0;
                sop_next   <= 1'b0;
            end
        end else if (is_ctl) begin
            if (is_eop) begin
                have_hi    <= 1'b0;
                pend_valid <= 1'b0;
                if (have_hi) begin
                    sop_next <= 1'b0;
                end
            end
            if (is_burst) begin
                cur_chan <= cw.chan;
                sop_next <= cw.sop;
            end
        end
    end

endmodule

/* core/sbr_framer.sv */
/*
 * Burst framer: cuts transmit segments into bursts on a link word stream
 * and delivers received packets on a receive segment.
 * Assumes one 128-bit segment, one clock, and a register port with read
 * data one cycle after the read strobe.
 */
// Design decisions made here: the plain strobed port and the register addresses.
// Operation
// - Packet mode, no forced burst: burst-max data words between controls.
// - Final bursts are sized from the minimum burst value.
// - Boundaries come from forced burst, short/max settings, channel change.
// - Forced-burst input inserts a burst control word like sop.
// - Settings enforced strictly; idles pad a short final burst.
// - Receive outputs are registered on the rising clock edge.
// - Receive data only appear with receive enable high.
// - Short packets show sop and eop in the same cycle.
// - First received byte sits in the top byte of the segment.
// - Full bus except on eop, where empty count gives invalid lanes.
// - Receive error on eop for check failure or error flag.
// - Received data keep link order; channel output tells packets apart.
// - Receive traffic halts only through the link's flow control.
// - Empty count N marks the N lowest bytes invalid.
// - With error and enable high, empty count low bits read zero.
`timescale 1ns/10ps
`include "sbr_regs.svh"

module sbr_framer
    import sbr_pkg::*;
(
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic [7:0]   reg_addr_i,
    input  wire logic [31:0]  reg_wdata_i,
    input  wire logic         reg_wr_i,
    input  wire logic         reg_rd_i,
    output logic [31:0]       reg_rdata_o,
    input  wire sbr_seg_type  tx_seg_i,
    output logic              tx_rdy_o,
    output sbr_link_type      tx_link_o,
    input  wire sbr_link_type rx_link_i,
    output sbr_seg_type       rx_seg_o
);

    // =================================================================
    // Register port.
    logic [15:0] burst_max_setting;
    logic [15:0] burst_short_setting;
    logic [7:0]  rx_pkt_cnt;

    wire sel_bmax   = (reg_addr_i == `SBR_BMAX_OFS);
    wire sel_bshort = (reg_addr_i == `SBR_BSHORT_OFS);
    wire sel_bmin   = (reg_addr_i == `SBR_BMIN_OFS);
    wire sel_status = (reg_addr_i == `SBR_STATUS_OFS);

    // Settings are counted in 8-byte link words.
    // A burst-max setting under eight bytes gives zero words:
    // every write then opens a new burst.
    wire [12:0] max_w = burst_max_setting[15:`SBR_WORD_SHIFT];
    wire [12:0] short_w = burst_short_setting[15:`SBR_WORD_SHIFT];
    // The scheduler's minimum burst equals burst-short here; the external
    // scheduler must use the forced-burst input for anything finer.
    wire [12:0] minimum_burst_value = short_w;

    logic [31:0]  status_word;
    logic [31:0]  next_rdata;

    // Writes land on the settings; anything else is ignored.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            burst_max_setting   <= `SBR_BMAX_RST;
            burst_short_setting <= `SBR_BSHORT_RST;
        end else if (reg_wr_i && sel_bmax) begin
            burst_max_setting   <= reg_wdata_i[15:0];
        end else if (reg_wr_i && sel_bshort) begin
            burst_short_setting <= reg_wdata_i[15:0];
        end
    end

    // Read mux; unmapped offsets read as zero.
    always_comb begin
        if (sel_bmax) begin
            next_rdata = {16'h0, burst_max_setting};
        end else if (sel_bshort) begin
            next_rdata = {16'h0, burst_short_setting};
        end else if (sel_bmin) begin
            next_rdata = {16'h0, minimum_burst_value, 3'h0};
        end else if (sel_status) begin
            next_rdata = status_word;
        end else begin
            next_rdata = 32'h0;
        end
    end

    // Read data stand only in the cycle after the strobe.
    // Zero between answers lets several ports be ORed.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 32'h0;
        end else begin
            reg_rdata_o <= reg_rd_i ? next_rdata : 32'h0;
        end
    end

    // =================================================================
    // Transmit burst state.
    sbr_tx_state_type state;
    sbr_tx_state_type next_state;
    // The taken write waits in hold until it is sent.
    sbr_seg_type      hold;
    logic [12:0]      burst_cnt;
    logic             burst_open;
    logic [10:0]      last_chan;
    logic [12:0]      pad_left;
    logic             eop_sent;

    // No input buffer: a write is taken only while the framer is idle,
    // which costs throughput but keeps every burst boundary exact.
    // A write offered while ready is low is lost.
    // The partner must watch ready first.
    assign tx_rdy_o = (state == ST_IDLE);
    wire take = tx_seg_i.ena & tx_rdy_o;

    // Any of these opens a new burst with a burst control word.
    // Checked between writes only: one control word each.
    wire chan_change = tx_seg_i.chan != last_chan;
    wire at_max      = burst_cnt >= max_w;
    wire new_burst   = tx_seg_i.sop | tx_seg_i.bctl
                     | chan_change | at_max | ~burst_open;

    // A last write with eight or more empty bytes skips its low half.
    // Its low half holds no packet byte.
    wire hi_only = hold.eop & hold.mty[`SBR_MTY_HALF_BIT];

    // Pad up to the minimum; a long final burst still gets one closing
    // idle word so that the end of packet reaches the far side.
    // The word now being sent counts toward the minimum.
    wire [12:0] cnt_after = burst_cnt + 13'h1;
    wire [12:0] pad_need =
        (minimum_burst_value > cnt_after) ?
        (minimum_burst_value - cnt_after) : 13'h1;

    wire to_pad = (state == ST_DHI) ? hi_only : hold.eop;

    // Next state.
    // Pad runs at least one cycle, so eop always goes out.
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = new_burst ? ST_CTL : ST_DHI;
                end
            end
            ST_CTL: begin
                next_state = ST_DHI;
            end
            ST_DHI: begin
                next_state = hi_only ? ST_PAD : ST_DLO;
            end
            ST_DLO: begin
                next_state = hold.eop ? ST_PAD : ST_IDLE;
            end
            ST_PAD: begin
                if (pad_left == 13'h1) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // =================================================================
    // Link word builder.
    // Outside a frame the link shows all zero words.
    sbr_cw_type   cw;
    sbr_link_type next_link;

    always_comb begin
        cw = '0;
        next_link = '0;
        case (state)
            ST_CTL: begin
                cw.kind = CW_BURST;
                cw.sop  = hold.sop;
                cw.chan = hold.chan;
                next_link = '{valid: 1'b1, ctl: 1'b1, data: cw};
            end
            ST_DHI: begin
                next_link = '{1'b1, 1'b0, hold.data[127:64]};
            end
            ST_DLO: begin
                next_link = '{1'b1, 1'b0, hold.data[63:0]};
            end
            ST_PAD: begin
                // Only the first idle word carries the end of packet.
                cw.kind = CW_IDLE;
                cw.eop  = ~eop_sent;
                cw.err  = ~eop_sent & hold.err;
                cw.mty  = eop_sent ? 3'h0 : hold.mty[2:0];
                cw.chan = hold.chan;
                next_link = '{valid: 1'b1, ctl: 1'b1, data: cw};
            end
            default: begin
                next_link = '0;
            end
        endcase
    end

    // State and link word registers.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state     <= ST_IDLE;
            tx_link_o <= '0;
        end else begin
            state     <= next_state;
            tx_link_o <= next_link;
        end
    end

    // =================================================================
    // Burst counting and write capture.
    // A burst control word or the last idle word
    // restarts the word count.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            hold       <= '0;
            burst_cnt  <= 13'h0;
            burst_open <= 1'b0;
            last_chan  <= 11'h0;
            pad_left   <= 13'h0;
            eop_sent   <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (take) begin
                        hold      <= tx_seg_i;
                        last_chan <= tx_seg_i.chan;
                    end
                end
                ST_CTL: begin
                    burst_cnt  <= 13'h0;
                    burst_open <= 1'b1;
                end
                ST_DHI, ST_DLO: begin
                    burst_cnt <= cnt_after;
                    if (to_pad) begin
                        pad_left <= pad_need;
                        eop_sent <= 1'b0;
                    end
                end
                ST_PAD: begin
                    pad_left <= pad_left - 13'h1;
                    eop_sent <= 1'b1;
                    if (pad_left == 13'h1) begin
                        burst_open <= 1'b0;
                        burst_cnt  <= 13'h0;
                    end
                end
                default: begin
                    burst_open <= 1'b0;
                end
            endcase
        end
    end

    // =================================================================
    // Receive side. There is no ready toward the link; the only brake on
    // incoming traffic is the link's flow control, outside this block.
    sbr_rx_deframe u_rx (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .link_i  (rx_link_i),
        .seg_o   (rx_seg_o)
    );

    // Count delivered packets so software can see the receive side move.
    // The packet count wraps at 256.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rx_pkt_cnt <= 8'h0;
        end else if (rx_seg_o.ena && rx_seg_o.eop) begin
            rx_pkt_cnt <= rx_pkt_cnt + 8'h1;
        end
    end

    // Status word assembly.
    // Bits not named below read as zero.
    always_comb begin
        status_word = 32'h0;
        status_word[12:0] = burst_cnt;
        status_word[`SBR_ST_OPEN_BIT] = burst_open;
        status_word[`SBR_ST_RDY_BIT] = tx_rdy_o;
        status_word[`SBR_ST_RXCNT_LSB +: 8] = rx_pkt_cnt;
    end

endmodule

/* verif/sbr_framer_chk.sv */
/*
 * Port checker for the burst framer.
 * Assumes it is bound into every sbr_framer and sees only its ports.
 */
`timescale 1ns/10ps

module sbr_framer_chk
    import sbr_pkg::*;
(
    input wire logic         mclk_i,
    input wire logic         rst_n_i,
    input wire logic         reg_rd_i,
    input wire logic [31:0]  reg_rdata_o,
    input wire sbr_seg_type  tx_seg_i,
    input wire logic         tx_rdy_o,
    input wire sbr_link_type tx_link_o,
    input wire sbr_link_type rx_link_i,
    input wire sbr_seg_type  rx_seg_o
);
    // ====================
    // Clocking and helpers.
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    // A write counts only while the framer is idle; lead opens a packet.
    wire logic take;
    wire logic lead;
    assign take = tx_seg_i.ena && tx_rdy_o;
    assign lead = take && tx_seg_i.sop;

    // ====================
    // Register port and transmit ready.
    rd_window_a:
        assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
        else $error("Read data outside the answer cycle.");
    rdy_drop_a:
        assert property (take |=> !tx_rdy_o)
        else $error("Ready stayed high after a taken write.");

    // ====================
    // Receive segment.
    rx_quiet_a:
        assert property (!rx_seg_o.ena |-> rx_seg_o == '0)
        else $error("Receive fields move without enable.");
    rx_cause_a:
        assert property (rx_seg_o.ena |-> $past(rx_link_i.valid))
        else $error("Receive segment without a link word.");
    rx_full_a:
        assert property (rx_seg_o.ena && !rx_seg_o.eop |->
            rx_seg_o.mty == 4'h0 && !rx_seg_o.err)
        else $error("Empty lanes or error off end of packet.");
    rx_err_a:
        assert property (rx_seg_o.ena && rx_seg_o.err |->
            rx_seg_o.eop && rx_seg_o.mty[2:0] == 3'h0)
        else $error("Receive error with wrong companions.");

    // ====================
    // Transmit link order: control, high word, low word, closing idle.
    bcw_first_a:
        assert property (take && (tx_seg_i.sop || tx_seg_i.bctl) |-> ##2
            tx_link_o.valid && tx_link_o.ctl &&
            tx_link_o.data[63:61] == {2'h1, $past(tx_seg_i.sop, 2)})
        else $error("Burst control word missing.");
    hi_first_a:
        assert property (lead |-> ##3 tx_link_o.valid && !tx_link_o.ctl
            && tx_link_o.data == $past(tx_seg_i.data[127:64], 3))
        else $error("High word not sent first.");
    lo_next_a:
        assert property (lead && !(tx_seg_i.eop && tx_seg_i.mty[3]) |->
            ##4 tx_link_o.valid && !tx_link_o.ctl &&
            tx_link_o.data == $past(tx_seg_i.data[63:0], 4))
        else $error("Low word not sent second.");
    pad_eop_a:
        assert property (lead && tx_seg_i.eop && !tx_seg_i.mty[3] |->
            ##5 tx_link_o.valid && tx_link_o.ctl &&
            tx_link_o.data[63:59] == {4'h1, $past(tx_seg_i.err, 5)})
        else $error("Closing idle word missing.");

    // ====================
    // Main scenarios seen.
    cover property (take && tx_seg_i.bctl);
    cover property (rx_seg_o.ena && rx_seg_o.sop && rx_seg_o.eop);
    cover property (rx_seg_o.ena && rx_seg_o.err);
endmodule

bind sbr_framer sbr_framer_chk u_chk (
    .mclk_i,
    .rst_n_i,
    .reg_rd_i,
    .reg_rdata_o,
    .tx_seg_i,
    .tx_rdy_o,
    .tx_link_o,
    .rx_link_i,
    .rx_seg_o
);

/* verif/sbr_user_model.sv */
/*
 * User-side model: writes transmit segments and takes receive segments.
 * Assumes the bench calls send only with legal packet sequences.
 */
`timescale 1ns/10ps

module sbr_user_model
    import sbr_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        tx_rdy_i,
    input  wire sbr_seg_type rx_seg_i,
    output sbr_seg_type      tx_seg_o
);
    sbr_seg_type rxq[$];

    // ====================
    // Receive side: every enabled cycle is taken, nothing can stall.
    always @(posedge mclk_i) begin
        if (rx_seg_i.ena === 1'b1) begin
            rxq.push_back(rx_seg_i);
        end
    end

    // ====================
    // Transmit side: one write per idle window, held for one cycle.
    initial begin
        tx_seg_o = '0;
    end

    // Whole packets, full buses and forced bursts come from the
    // caller; the model only spaces writes by ready.
    task automatic send(input sbr_seg_type s);
        int n;
        n = 0;
        do begin
            @(negedge mclk_i);
            n++;
        end while (tx_rdy_i !== 1'b1 && n < 100);
        if (tx_rdy_i !== 1'b1) begin
            testbench.err_total++;
        end
        @(posedge mclk_i);
        tx_seg_o <= s;
        @(posedge mclk_i);
        // Inverted stale fields show that enable alone qualifies them.
        s = ~s;
        s.ena = 1'b0;
        tx_seg_o <= s;
    endtask
endmodule

/* verif/testbench.sv */
/*
 * Testbench for the burst framer with its link looped back to itself.
 * Assumes the user model and the checker are compiled beforehand.
 */
`timescale 1ns/10ps

module testbench
    import sbr_pkg::*;
();
    logic         mclk;
    logic         rst_n;
    logic [7:0]   reg_addr;
    logic [31:0]  reg_wdata;
    logic         reg_wr;
    logic         reg_rd;
    logic [31:0]  reg_rdata;
    sbr_seg_type  tx_seg;
    logic         tx_rdy;
    sbr_link_type tx_link;
    sbr_seg_type  rx_seg;
    int           err_total = 0;
    int           comparisons = 0;
    int unsigned  dcnt = 0;
    int unsigned  idles = 0;
    int unsigned  bq[$];
    sbr_seg_type  expq[$];

    // ====================
    // Clock, design and user model; transmit words feed receive.
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    sbr_framer uut (
        .mclk_i      (mclk),
        .rst_n_i     (rst_n),
        .reg_addr_i  (reg_addr),
        .reg_wdata_i (reg_wdata),
        .reg_wr_i    (reg_wr),
        .reg_rd_i    (reg_rd),
        .reg_rdata_o (reg_rdata),
        .tx_seg_i    (tx_seg),
        .tx_rdy_o    (tx_rdy),
        .tx_link_o   (tx_link),
        .rx_link_i   (tx_link),
        .rx_seg_o    (rx_seg)
    );

    sbr_user_model u_user (
        .mclk_i   (mclk),
        .tx_rdy_i (tx_rdy),
        .rx_seg_i (rx_seg),
        .tx_seg_o (tx_seg)
    );

    // Burst lengths in data words and idle words seen on the link.
    always @(posedge mclk) begin
        if (tx_link.valid && tx_link.ctl) begin
            if (dcnt != 0) begin
                bq.push_back(dcnt);
            end
            dcnt = 0;
            idles += (tx_link.data[63:62] == 2'h0);
        end else if (tx_link.valid) begin
            dcnt++;
        end
    end

    // ====================
    // Compare, bus and helper tasks.
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %0h, expected %0h", $time, got, exp);
        end
    endtask

    // From eight empty lanes on, only the high word carries packet bytes.
    task automatic chk_seg(input sbr_seg_type got, input sbr_seg_type exp);
        comparisons++;
        if (exp.mty[3]) begin
            got.data[63:0] = '0;
            exp.data[63:0] = '0;
        end
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %0h, expected %0h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk_val(reg_rdata, e);
    endtask

    // Flags f are sop, eop, err and bctl from the top bit down.
    function automatic sbr_seg_type sg(input logic [3:0] f,
        input logic [10:0] ch, input logic [3:0] m, input logic [7:0] b);
        return '{1'b1, f[3], f[2], f[1], f[0], ch, m,
                 {b, 120'h00112233445566778899aabbccddee}};
    endfunction

    task automatic pkt(input sbr_seg_type s);
        sbr_seg_type e;
        e = s;
        e.bctl = 1'b0;
        if (s.err) begin
            e.mty[2:0] = 3'h0;
        end
        expq.push_back(e);
        u_user.send(s);
    endtask

    task automatic check_rx;
        chk_val(32'(u_user.rxq.size()), 32'(expq.size()));
        while (expq.size() > 0 && u_user.rxq.size() > 0) begin
            chk_seg(u_user.rxq.pop_front(), expq.pop_front());
        end
    endtask

    task automatic begin_run(input logic [31:0] bmax, input logic [31:0] bs);
        bq.delete();
        expq.delete();
        u_user.rxq.delete();
        idles = 0;
        reg_write(8'h00, bmax);
        reg_write(8'h04, bs);
        reg_read(8'h08, bs);
    endtask

    task automatic settle;
        repeat (24) @(posedge mclk);
        @(negedge mclk);
    endtask

    // ====================
    // Scenarios.
    task automatic run_regs;
        reg_read(8'h00, 32'h100);
        reg_read(8'h04, 32'h40);
        reg_read(8'h10, 32'h0);
        reg_read(8'h0c, 32'h20000);
        reg_write(8'h08, 32'h1234);
        reg_read(8'h08, 32'h40);
    endtask

    task automatic run_max;
        begin_run(32'h20, 32'h10);
        pkt(sg(4'h8, 11'h3, 4'h0, 8'h10));
        pkt(sg(4'h0, 11'h3, 4'h0, 8'h11));
        pkt(sg(4'h0, 11'h3, 4'h0, 8'h12));
        pkt(sg(4'h4, 11'h3, 4'h0, 8'h13));
        settle();
        chk_val(32'(bq.size()), 32'h2);
        chk_val(32'(bq[0]), 32'h4);
        chk_val(32'(bq[1]), 32'h4);
        chk_val(32'(idles), 32'h1);
        check_rx();
    endtask

    task automatic run_pad;
        begin_run(32'h100, 32'h40);
        pkt(sg(4'hc, 11'h7, 4'h3, 8'h20));
        settle();
        chk_val(32'(bq[0]), 32'h2);
        chk_val(32'(idles), 32'h6);
        check_rx();
    endtask

    task automatic run_bctl;
        begin_run(32'h100, 32'h10);
        pkt(sg(4'h8, 11'h2, 4'h0, 8'h30));
        pkt(sg(4'h1, 11'h2, 4'h0, 8'h31));
        pkt(sg(4'h4, 11'h2, 4'h0, 8'h32));
        settle();
        chk_val(32'(bq.size()), 32'h2);
        chk_val(32'(bq[0]), 32'h2);
        chk_val(32'(bq[1]), 32'h4);
        check_rx();
    endtask

    task automatic run_mix;
        begin_run(32'h100, 32'h10);
        pkt(sg(4'h8, 11'h1, 4'h0, 8'h40));
        pkt(sg(4'h8, 11'h2, 4'h0, 8'h41));
        pkt(sg(4'h4, 11'h1, 4'h0, 8'h42));
        pkt(sg(4'h4, 11'h2, 4'h9, 8'h43));
        pkt(sg(4'he, 11'h4, 4'h5, 8'h44));
        settle();
        chk_val(32'(bq.size()), 32'h5);
        chk_val(32'(bq[3]), 32'h1);
        check_rx();
        reg_read(8'h0c, 32'h06020000);
    endtask

    // ====================
    // Verdict, main sequence and watchdog.
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        run_regs();
        run_max();
        run_pad();
        run_bctl();
        run_mix();
        give_verdict();
    end

    // The whole run needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        give_verdict();
    end
endmodule
